// [rtl/dit_trigger_unit.sv]
// Dual interrupt trigger unit with AHB-Lite register access.
//
// Summary of operation
// - Output re-falls five clocks after rising, if pending.
// - Partial clear of pending bits re-asserts output.
// - New factor during clear still latches, re-asserts.
// - Alarm factor at programmed slot every cycle.
// - Renewal factor at slot when watched blocks changed.
// - Mail received bit 2; mail send done bit 3.
// - Group mismatch/incomplete rising edges set bits 4,5.
// - Resize done 6, network stop 7, run 8.
// - Member flag count change sets bit 9.
// - Link group judged good 10, bad 11.
// - Break station seen 12, resize overlap 13.
// - Ping arrival 14, jammer seen 15.
// - Second output identical with its own registers.
// - Slots beyond last station plus two never trigger.
// - Renewal slot beyond range never updates flags.
// - Only one output may own renewal enable.
// - Renewal timed by owner's slot field.
// - Renewal flags fall at owner slot, default first.
// - Enabled factor latches, write one clears, idle high.
// - Latched bit survives disabling its enable.
// - Timing holds alarm slot low, renewal slot high.
// - Reset clears every enable bit.
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module dit_trigger_unit import dit_pkg::*; #(
	parameter int unsigned NBLOCKS = BLOCKS
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Cycle timing
	input wire logic [SLOT_W-1:0] slot_time,
	input wire logic slot_tick,
	input wire logic [STATION_W-1:0] last_station_number,
	// Shared memory renewal watch
	input wire logic [NBLOCKS-1:0] block_written,
	input wire logic [NBLOCKS-1:0] renewal_watch_mask,
	// Membership and link status
	input wire logic [NBLOCKS-1:0] member_flags,
	input wire logic member_group_mismatch,
	input wire logic member_group_incomplete,
	input wire logic [NBLOCKS-1:0] link_flags,
	input wire logic [NBLOCKS-1:0] link_group_mask,
	// Network event pulses
	input wire dit_evt_s evt,
	// Interrupt outputs
	output logic irq_out_a_n,
	output logic irq_out_b_n,
	// Renewal state
	output logic [NBLOCKS-1:0] renewal_flags,
	output logic renewal_status
);

	// The flag vectors and the popcount width are sized for one fixed block count.
	initial begin
		if (NBLOCKS != BLOCKS) begin
			$error("dit_trigger_unit: NBLOCKS must equal the block count");
		end
		if ((1 << CNT_W) <= BLOCKS) begin
			$error("dit_trigger_unit: member count too narrow");
		end
	end

	// ============================================================
	// Helpers
	// Population count of a flag vector; seven bits hold every count up to the block count.
	function automatic logic [CNT_W-1:0] ones(input logic [BLOCKS-1:0] v);
		logic [CNT_W-1:0] n;
		n = '0;
		for (int i = 0; i < BLOCKS; i++) begin
			n = n + CNT_W'(v[i]);
		end
		return n;
	endfunction

	// Slot reachable in a cycle: at most last station plus the margin.
	function automatic logic slot_ok(input logic [SLOT_W-1:0] slot, input logic [STATION_W-1:0] fs);
		return {1'b0, slot} <= ({2'h0, fs} + SLOT_MARGIN);
	endfunction

	dit_top_s s_q;
	dit_top_s s_d;

	logic addr_ok;
	logic [ADDR_W-1:0] aofs;
	logic [NUM_FACTORS-1:0] factor;
	logic [NUM_FACTORS-1:0] pend_a;
	logic [NUM_FACTORS-1:0] pend_b;
	logic clr_a_we;
	logic clr_b_we;
	logic [SLOT_W-1:0] alm_a;
	logic [SLOT_W-1:0] alm_b;
	logic [SLOT_W-1:0] dr_slot;
	logic alm_hit_a;
	logic alm_hit_b;
	logic dr_point;
	logic [NBLOCKS-1:0] dr_new;
	logic [CNT_W-1:0] mcount_now;
	logic link_good;
	logic [15:0] en_b_wr;
	logic [15:0] en_a_wr;
	logic alm_ok_a;
	logic alm_ok_b;
	logic dr_ok;

	// ============================================================
	// Bus decode
	// The slave never stalls, so a write lands at the edge that ends its data phase, when hwdata stands.
	// Pending clears use that same data phase, so a clear and a new factor can meet in one cycle.
	assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	assign aofs = haddr[ADDR_W-1:0];
	assign clr_a_we = s_q.wr && (s_q.addr == OFS_PEND_A);
	assign clr_b_we = s_q.wr && (s_q.addr == OFS_PEND_B);

	// ============================================================
	// Slot matching
	assign alm_a = s_q.tim_a[TIM_ALM_LSB +: SLOT_W];
	assign alm_b = s_q.tim_b[TIM_ALM_LSB +: SLOT_W];
	// The owner's renewal field times renewal; the first output's field is the fallback.
	always_comb begin
		if (s_q.en_a[BIT_DR]) begin
			dr_slot = s_q.tim_a[TIM_DR_LSB +: SLOT_W];
		end else if (s_q.en_b[BIT_DR]) begin
			dr_slot = s_q.tim_b[TIM_DR_LSB +: SLOT_W];
		end else begin
			dr_slot = s_q.tim_a[TIM_DR_LSB +: SLOT_W];
		end
	end
	// Out-of-range slots never match, so they never trigger or update.
	// The limit follows the final station number live, so a shrunk cycle disarms a slot at once.
	assign alm_ok_a = slot_ok(alm_a, last_station_number);
	assign alm_ok_b = slot_ok(alm_b, last_station_number);
	assign dr_ok = slot_ok(dr_slot, last_station_number);
	assign alm_hit_a = slot_tick && (slot_time == alm_a) && alm_ok_a;
	assign alm_hit_b = slot_tick && (slot_time == alm_b) && alm_ok_b;
	assign dr_point = slot_tick && (slot_time == dr_slot) && dr_ok;
	assign dr_new = block_written & renewal_watch_mask;

	// ============================================================
	// Factor sources
	// The count is compared every cycle, so a change that reverts next cycle still raises bit 9.
	assign mcount_now = ones(member_flags);
	// Link judgement counts only on the judge pulse; flags that flicker between pulses are ignored.
	assign link_good = (link_flags & link_group_mask) == link_group_mask;

	always_comb begin
		factor = '0;
		// Each channel matches ALARM_FACTOR against its own alarm slot field, so one shared bit is not enough.
		factor[BIT_ALM] = 1'b0;
		factor[BIT_DR] = dr_point && ((s_q.dr_flags | dr_new) != '0);
		factor[BIT_MAIL_RX] = evt.mail_arrival;
		factor[BIT_MAIL_DONE] = evt.mail_send_done;
		factor[BIT_MG_MISMATCH] = member_group_mismatch && !s_q.mg_mismatch;
		factor[BIT_MG_INCOMPLETE] = member_group_incomplete && !s_q.mg_incomplete;
		factor[BIT_RESIZE_DONE] = evt.resize_complete;
		factor[BIT_RUN_HALT] = evt.run_halt;
		factor[BIT_RUN_BEGIN] = evt.run_begin;
		factor[BIT_MEMBER_CHG] = s_q.mvalid && (mcount_now != s_q.mcount);
		factor[BIT_LINK_GOOD] = evt.link_judge && link_good;
		factor[BIT_LINK_BAD] = evt.link_judge && !link_good;
		factor[BIT_BREAK] = evt.break_seen;
		factor[BIT_OVERLAP] = evt.resize_overlap;
		factor[BIT_PING] = evt.ping_arrival;
		factor[BIT_JAMMER] = evt.jammer_seen;
	end

	logic [NUM_FACTORS-1:0] factor_a;
	logic [NUM_FACTORS-1:0] factor_b;
	always_comb begin
		factor_a = factor;
		factor_b = factor;
		factor_a[BIT_ALM] = alm_hit_a;
		factor_b[BIT_ALM] = alm_hit_b;
	end

	// ============================================================
	// Enable write protection for renewal ownership
	always_comb begin
		en_a_wr = hwdata[15:0];
		en_b_wr = hwdata[15:0];
		// Ownership is first come: once the owner drops its bit, the other output may take renewal.
		// A set renewal enable in the other output blocks writing a one here.
		if (s_q.en_b[BIT_DR]) begin
			en_a_wr[BIT_DR] = 1'b0;
		end
		if (s_q.en_a[BIT_DR]) begin
			en_b_wr[BIT_DR] = 1'b0;
		end
	end

	// ============================================================
	// Next state
	always_comb begin
		s_d = s_q;
		// Data phase of a write.
		if (s_q.wr) begin
			case (s_q.addr)
				OFS_EN_A: begin
					s_d.en_a = en_a_wr;
				end
				OFS_EN_B: begin
					s_d.en_b = en_b_wr;
				end
				OFS_TIM_A: begin
					s_d.tim_a = hwdata[15:0];
				end
				OFS_TIM_B: begin
					s_d.tim_b = hwdata[15:0];
				end
				default: begin
					s_d.en_a = s_q.en_a;
				end
			endcase
		end

		// Address phase: capture writes, prefetch read data so it comes from a flop.
		// A read right after a write to the same register therefore returns the old value.
		s_d.wr = addr_ok && hwrite;
		s_d.addr = aofs;
		if (addr_ok && !hwrite) begin
			case (aofs)
				OFS_EN_A: begin
					s_d.rdata = {16'h0000, s_q.en_a};
				end
				OFS_EN_B: begin
					s_d.rdata = {16'h0000, s_q.en_b};
				end
				OFS_TIM_A: begin
					s_d.rdata = {16'h0000, s_q.tim_a};
				end
				OFS_TIM_B: begin
					s_d.rdata = {16'h0000, s_q.tim_b};
				end
				OFS_PEND_A: begin
					s_d.rdata = {16'h0000, pend_a};
				end
				OFS_PEND_B: begin
					s_d.rdata = {16'h0000, pend_b};
				end
				OFS_SYS: begin
					s_d.rdata = 32'h0000_0000;
					s_d.rdata[SYS_DR_BIT] = s_q.dr_stat;
				end
				default: begin
					s_d.rdata = 32'h0000_0000;
				end
			endcase
		end

		// Edge detectors and member count history.
		s_d.mg_mismatch = member_group_mismatch;
		s_d.mg_incomplete = member_group_incomplete;
		s_d.mcount = mcount_now;
		s_d.mvalid = 1'b1;

		// Renewal flags fall at the update point; writes in that same cycle still set.
		// A block written at the update point joins the next window instead of being lost.
		s_d.dr_flags = (dr_point ? '0 : s_q.dr_flags) | dr_new;
		s_d.dr_stat = (s_d.dr_flags != '0);
	end

	// ============================================================
	// State register
	// Every field has a reset value, so no state leaves reset unknown.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q.en_a <= EN_RST;
			s_q.en_b <= EN_RST;
			s_q.tim_a <= TIM_RST;
			s_q.tim_b <= TIM_RST;
			s_q.wr <= 1'b0;
			s_q.addr <= '0;
			s_q.rdata <= 32'h0000_0000;
			s_q.mg_mismatch <= 1'b0;
			s_q.mg_incomplete <= 1'b0;
			s_q.mcount <= '0;
			s_q.mvalid <= 1'b0;
			s_q.dr_flags <= '0;
			s_q.dr_stat <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ============================================================
	// Interrupt channels
	// Host EOI ordering is left to software; the gap only guarantees a clean edge.
	// Both outputs share the factor vector; only the alarm bit, the enable mask and the pending clear strobe differ.
	dit_irq_chan #(
		.WIDTH(NUM_FACTORS),
		.GAP(RETRIG_CLKS)
	) u_chan_a (
		.hclk(hclk),
		.hresetn(hresetn),
		.factor(factor_a),
		.enable(s_q.en_a),
		.clr_we(clr_a_we),
		.clr_mask(hwdata[15:0]),
		.pending(pend_a),
		.irq_n(irq_out_a_n)
	);

	// The second output mirrors the first with its own registers.
	dit_irq_chan #(
		.WIDTH(NUM_FACTORS),
		.GAP(RETRIG_CLKS)
	) u_chan_b (
		.hclk(hclk),
		.hresetn(hresetn),
		.factor(factor_b),
		.enable(s_q.en_b),
		.clr_we(clr_b_we),
		.clr_mask(hwdata[15:0]),
		.pending(pend_b),
		.irq_n(irq_out_b_n)
	);

	// ============================================================
	// Outputs
	// Zero wait states and an OKAY response are fixed, so no error path exists.
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;
	assign hrdata = s_q.rdata;
	assign renewal_flags = s_q.dr_flags;
	assign renewal_status = s_q.dr_stat;

endmodule

// [rtl/dit_pkg.sv]
// Shared constants and types for the dual interrupt trigger unit.
package dit_pkg;

	// ============================================================
	// Register map (byte offsets, one aligned word each)
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFS_EN_A = 8'h00;
	localparam logic [7:0] OFS_EN_B = 8'h04;
	localparam logic [7:0] OFS_TIM_A = 8'h08;
	localparam logic [7:0] OFS_TIM_B = 8'h0C;
	localparam logic [7:0] OFS_PEND_A = 8'h10;
	localparam logic [7:0] OFS_PEND_B = 8'h14;
	localparam logic [7:0] OFS_SYS = 8'h18;

	// ============================================================
	// Reset values
	localparam logic [15:0] EN_RST = 16'h0000;
	localparam logic [15:0] TIM_RST = 16'h0000;
	localparam logic [15:0] PEND_RST = 16'h0000;

	// ============================================================
	// Factor bit positions
	localparam int unsigned NUM_FACTORS = 16;
	localparam int unsigned BIT_ALM = 0;
	localparam int unsigned BIT_DR = 1;
	localparam int unsigned BIT_MAIL_RX = 2;
	localparam int unsigned BIT_MAIL_DONE = 3;
	localparam int unsigned BIT_MG_MISMATCH = 4;
	localparam int unsigned BIT_MG_INCOMPLETE = 5;
	localparam int unsigned BIT_RESIZE_DONE = 6;
	localparam int unsigned BIT_RUN_HALT = 7;
	localparam int unsigned BIT_RUN_BEGIN = 8;
	localparam int unsigned BIT_MEMBER_CHG = 9;
	localparam int unsigned BIT_LINK_GOOD = 10;
	localparam int unsigned BIT_LINK_BAD = 11;
	localparam int unsigned BIT_BREAK = 12;
	localparam int unsigned BIT_OVERLAP = 13;
	localparam int unsigned BIT_PING = 14;
	localparam int unsigned BIT_JAMMER = 15;

	// ============================================================
	// Timing register fields and slot limits
	localparam int unsigned SLOT_W = 7;
	localparam int unsigned STATION_W = 6;
	localparam int unsigned TIM_ALM_LSB = 0;
	localparam int unsigned TIM_DR_LSB = 8;
	localparam logic [7:0] SLOT_MARGIN = 8'h02;
	localparam int unsigned SYS_DR_BIT = 11;
	localparam int unsigned BLOCKS = 64;
	localparam int unsigned CNT_W = 7;

	// ============================================================
	// Re-assertion gap in device clocks
	localparam int unsigned RETRIG_CLKS = 5;
	localparam int unsigned GAP_W = 4;

	// ============================================================
	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic HRESP_OKAY = 1'h0;

	// ============================================================
	// Carriers and state
	typedef struct packed {
		logic mail_arrival;
		logic mail_send_done;
		logic resize_complete;
		logic run_halt;
		logic run_begin;
		logic link_judge;
		logic break_seen;
		logic resize_overlap;
		logic ping_arrival;
		logic jammer_seen;
	} dit_evt_s;

	typedef struct packed {
		logic [NUM_FACTORS-1:0] pend;
		logic [GAP_W-1:0] gap;
		logic irq_n;
	} dit_chan_s;

	typedef struct packed {
		logic [15:0] en_a;
		logic [15:0] en_b;
		logic [15:0] tim_a;
		logic [15:0] tim_b;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [31:0] rdata;
		logic mg_mismatch;
		logic mg_incomplete;
		logic [CNT_W-1:0] mcount;
		logic mvalid;
		logic [BLOCKS-1:0] dr_flags;
		logic dr_stat;
	} dit_top_s;

endpackage

// [rtl/dit_irq_chan.sv]
// One interrupt output: pending latch, clear-by-one and re-assertion gap.
`timescale 1ns/1ps
module dit_irq_chan import dit_pkg::*; #(
	parameter int unsigned WIDTH = NUM_FACTORS,
	parameter int unsigned GAP = RETRIG_CLKS
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Factor pulses and enables
	input wire logic [WIDTH-1:0] factor,
	input wire logic [WIDTH-1:0] enable,
	// Software clear
	input wire logic clr_we,
	input wire logic [WIDTH-1:0] clr_mask,
	// Results
	output logic [WIDTH-1:0] pending,
	output logic irq_n
);

	initial begin
		if (WIDTH != NUM_FACTORS || GAP < 1 || GAP >= (1 << GAP_W)) begin
			$error("dit_irq_chan: unsupported WIDTH or GAP");
		end
	end

	dit_chan_s s_q;
	dit_chan_s s_d;
	logic clr_hit;

	// ============================================================
	// Next state
	always_comb begin
		s_d = s_q;
		clr_hit = clr_we && ((s_q.pend & clr_mask) != '0);
		// A latched bit survives a later enable clear; a new factor beats a clear.
		s_d.pend = (s_q.pend & ~(clr_we ? clr_mask : '0)) | (factor & enable);
		if (clr_hit) begin
			// Any effective clear opens a high gap, so an edge-sensing host sees a fresh fall.
			s_d.gap = GAP_W'(GAP);
		end else if (s_q.gap != '0) begin
			s_d.gap = s_q.gap - 1'b1;
		end
		// Low while anything is pending, except during the gap.
		s_d.irq_n = (s_d.gap != '0) || (s_d.pend == '0);
	end

	// ============================================================
	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q.pend <= PEND_RST;
			s_q.gap <= '0;
			s_q.irq_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign pending = s_q.pend;
	assign irq_n = s_q.irq_n;

endmodule

// [test/dit_chk.sv]
// Assertion checker for the dual interrupt trigger unit.
`timescale 1ns/1ps
module dit_chk import dit_pkg::*; #(
	parameter int unsigned NBLOCKS = BLOCKS
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	// Cycle timing and events
	input wire logic [SLOT_W-1:0] slot_time,
	input wire logic slot_tick,
	input wire logic [STATION_W-1:0] last_station_number,
	input wire logic member_group_mismatch,
	input wire dit_evt_s evt,
	// Outputs
	input wire logic irq_out_a_n,
	input wire logic irq_out_b_n,
	input wire logic [NBLOCKS-1:0] renewal_flags
);
	// ==========
	// Shadow of bus writes, updated at the edge that ends the data phase
	logic wr_q;
	logic [7:0] ad_q;
	logic [15:0] en_q;
	logic [15:0] tim_q;
	logic [15:0] ef;
	logic [6:0] lim;
	logic clr_a;
	logic clr_b;
	logic alarm_factor;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			ad_q <= 8'h00;
			en_q <= 16'h0000;
			tim_q <= 16'h0000;
		end else begin
			wr_q <= hsel && hready && htrans[1] && hwrite;
			ad_q <= haddr[7:0];
			if (wr_q && ad_q == OFS_EN_A) begin
				en_q <= hwdata[15:0];
			end
			if (wr_q && ad_q == OFS_TIM_A) begin
				tim_q <= hwdata[15:0];
			end
		end
	end

	assign lim = {1'b0, last_station_number} + 7'h02;
	assign alarm_factor = slot_tick && slot_time == tim_q[6:0] && slot_time <= lim && en_q[0];
	assign clr_a = wr_q && ad_q == OFS_PEND_A;
	assign clr_b = wr_q && ad_q == OFS_PEND_B;
	assign ef = {evt.jammer_seen, evt.ping_arrival, evt.resize_overlap, evt.break_seen, 3'h0, evt.run_begin,
		evt.run_halt, evt.resize_complete, 2'h0, evt.mail_send_done, evt.mail_arrival, 2'h0};

	// ==========
	// Properties
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	rst_idle_a: assert property ($rose(hresetn) |-> irq_out_a_n && irq_out_b_n && renewal_flags == '0)
		else $error("outputs not idle after reset");
	gap_a_a: assert property ($rose(irq_out_a_n) |-> irq_out_a_n[*5])
		else $error("output a gap is not five clocks");
	gap_b_a: assert property ($rose(irq_out_b_n) |-> irq_out_b_n[*5])
		else $error("output b gap is not five clocks");
	rise_a_a: assert property ($rose(irq_out_a_n) |-> $past(clr_a))
		else $error("output a released without a clear");
	rise_b_a: assert property ($rose(irq_out_b_n) |-> $past(clr_b))
		else $error("output b released without a clear");
	alarm_hit_a: assert property (alarm_factor |-> ##[1:6] !irq_out_a_n)
		else $error("alarm slot gave no request");
	evt_req_a: assert property ((|(ef & en_q)) |-> ##[1:6] !irq_out_a_n)
		else $error("enabled event gave no request");
	mg_edge_a: assert property ($rose(member_group_mismatch) && en_q[BIT_MG_MISMATCH] |-> ##[1:6] !irq_out_a_n)
		else $error("group mismatch edge gave no request");
	dr_hold_a: assert property (renewal_flags != '0 && !slot_tick |=> renewal_flags != '0)
		else $error("renewal flags fell outside a slot");

	cover property ($rose(irq_out_a_n) ##5 !irq_out_a_n);
	cover property (alarm_factor);
	cover property (clr_a && ef != 16'h0000);
endmodule
bind dit_trigger_unit dit_chk #(.NBLOCKS(NBLOCKS)) u_dit_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .slot_time, .slot_tick, .last_station_number, .member_group_mismatch, .evt,
	.irq_out_a_n, .irq_out_b_n, .renewal_flags);

// [test/dit_host_irqc.sv]
// Behavioural host interrupt controller with edge or level sensing.
`timescale 1ns/1ps
module dit_host_irqc (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Request line and host control
	input wire logic irq_n,
	input wire logic level_mode,
	input wire logic eoi,
	// Accepted requests
	output logic [7:0] taken
);
	// ==========
	// Acceptance stays blocked from one request to the next end-of-interrupt,
	// so an edge that lands in that window is lost, as on a real controller.
	logic armed_q;
	logic irq_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			armed_q <= 1'b1;
			irq_q <= 1'b1;
			taken <= 8'h00;
		end else begin
			irq_q <= irq_n;
			if (eoi) begin
				armed_q <= 1'b1;
			end else if (armed_q && !irq_n && (level_mode || irq_q)) begin
				armed_q <= 1'b0;
				taken <= taken + 8'h01;
			end
		end
	end
endmodule

// [test/dit_trigger_unit_tb.sv]
// Self-checking bench for the dual interrupt trigger unit.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module dit_trigger_unit_tb import dit_pkg::*;;
	// ==========
	// Signals
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slot_tick = 1'b0, eoi = 1'b0;
	logic member_group_mismatch = 1'b0, member_group_incomplete = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [6:0] slot_time = 7'h00;
	logic [5:0] last_station_number = 6'h03;
	logic [63:0] block_written = '0, renewal_watch_mask = '0, member_flags = '0, link_flags = '0;
	logic [63:0] link_group_mask = '0, renewal_flags;
	logic hreadyout, hresp, irq_out_a_n, irq_out_b_n, renewal_status;
	logic [7:0] tk_a, tk_b;
	dit_evt_s evt = '0;
	int n_mismatch = 0, check_count = 0;

	initial begin
		forever #12.5 hclk = ~hclk;
	end

	dit_trigger_unit u_dit_trigger_unit (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .slot_time, .slot_tick, .last_station_number,
		.block_written, .renewal_watch_mask, .member_flags, .member_group_mismatch, .member_group_incomplete,
		.link_flags, .link_group_mask, .evt, .irq_out_a_n, .irq_out_b_n, .renewal_flags, .renewal_status);
	dit_host_irqc u_dit_host_irqc (.hclk, .hresetn, .irq_n(irq_out_a_n), .level_mode(1'b0), .eoi, .taken(tk_a));
	dit_host_irqc u_dit_host_irqc_b (.hclk, .hresetn, .irq_n(irq_out_b_n), .level_mode(1'b1), .eoi, .taken(tk_b));

	// ==========
	// Shared tasks
	task automatic wrap_up;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic wt;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 20);
		if (hreadyout !== 1'b1) begin
			n_mismatch++;
			$display("ERROR hready exp 1 got %b", hreadyout);
			wrap_up;
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		wt;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0, d};
		wt;
		r = hrdata;
		@(negedge hclk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0);
		`CHK("register", e, r[15:0])
	endtask
	task automatic pulse(input dit_evt_s e);
		@(posedge hclk);
		evt <= e;
		@(posedge hclk);
		evt <= '0;
		@(negedge hclk);
	endtask
	task automatic tick(input logic [6:0] s);
		@(posedge hclk);
		slot_time <= s;
		slot_tick <= 1'b1;
		@(posedge hclk);
		slot_tick <= 1'b0;
		@(negedge hclk);
	endtask
	task automatic ack;
		@(posedge hclk);
		eoi <= 1'b1;
		@(posedge hclk);
		eoi <= 1'b0;
	endtask

	// ==========
	// Scenarios
	task automatic t_reset;
		for (int k = 0; k < 8; k++) begin
			rdc(8'(k * 4), 16'h0000);
		end
		`CHK("hresp", HRESP_OKAY, hresp)
		bus(1'b1, OFS_TIM_B, 16'h7F7F);
		rdc(OFS_TIM_B, 16'h7F7F);
		$display("test reset done");
	endtask
	task automatic t_mail;
		bus(1'b1, OFS_EN_A, 16'hFFFF);
		pulse(10'h200);
		rdc(OFS_PEND_A, 16'h0004);
		`CHK("irq_a", 1'b0, irq_out_a_n)
		bus(1'b1, OFS_EN_A, 16'hFFFB);
		rdc(OFS_PEND_A, 16'h0004);
		ack;
		bus(1'b1, OFS_PEND_A, 16'h0004);
		`CHK("irq_a", 1'b1, irq_out_a_n)
		`CHK("host_a", 8'h01, tk_a)
		$display("test mail done");
	endtask
	task automatic t_retrig;
		int map[10] = '{15, 14, 13, 12, 0, 8, 7, 6, 3, 2};
		logic [15:0] ex;
		ex = 16'h0000;
		bus(1'b1, OFS_EN_A, 16'hFFFF);
		for (int i = 0; i < 10; i++) begin
			if (i != 4) begin
				pulse(10'(1 << i));
				ex[map[i]] = 1'b1;
			end
		end
		rdc(OFS_PEND_A, ex);
		ack;
		bus(1'b1, OFS_PEND_A, 16'h1000);
		repeat (5) begin
			`CHK("irq_a", 1'b1, irq_out_a_n)
			@(negedge hclk);
		end
		`CHK("irq_a", 1'b0, irq_out_a_n)
		rdc(OFS_PEND_A, ex & 16'hEFFF);
		`CHK("host_a", 8'h03, tk_a)
		ack;
		bus(1'b1, OFS_PEND_A, 16'hFFFF);
		repeat (7) @(negedge hclk);
		`CHK("irq_a", 1'b1, irq_out_a_n)
		$display("test retrigger done");
	endtask
	task automatic t_same;
		pulse(10'h008);
		ack;
		fork
			bus(1'b1, OFS_PEND_A, 16'h1000);
			begin
				repeat (2) @(posedge hclk);
				evt <= 10'h200;
				@(posedge hclk);
				evt <= '0;
			end
		join
		`CHK("irq_a", 1'b1, irq_out_a_n)
		repeat (5) @(negedge hclk);
		`CHK("irq_a", 1'b0, irq_out_a_n)
		rdc(OFS_PEND_A, 16'h0004);
		ack;
		bus(1'b1, OFS_PEND_A, 16'h0004);
		$display("test same cycle done");
	endtask
	task automatic t_member;
		bus(1'b1, OFS_EN_B, 16'hFFFF);
		rdc(OFS_EN_B, 16'hFFFD);
		@(posedge hclk);
		member_group_mismatch <= 1'b1;
		member_group_incomplete <= 1'b1;
		member_flags <= 64'h1;
		link_group_mask <= 64'h3;
		link_flags <= 64'h3;
		pulse(10'h010);
		@(posedge hclk);
		link_flags <= 64'h1;
		pulse(10'h010);
		rdc(OFS_PEND_B, 16'h0E30);
		rdc(OFS_PEND_A, 16'h0E30);
		bus(1'b1, OFS_PEND_B, 16'hFFFF);
		ack;
		@(negedge hclk);
		`CHK("host_b", 8'h01, tk_b)
		`CHK("irq_b", 1'b1, irq_out_b_n)
		bus(1'b1, OFS_PEND_A, 16'hFFFF);
		$display("test member done");
	endtask
	task automatic t_alarm;
		bus(1'b1, OFS_TIM_A, 16'h0405);
		tick(7'h05);
		rdc(OFS_PEND_A, 16'h0001);
		bus(1'b1, OFS_PEND_A, 16'h0001);
		bus(1'b1, OFS_TIM_A, 16'h0406);
		tick(7'h06);
		rdc(OFS_PEND_A, 16'h0000);
		$display("test alarm done");
	endtask
	task automatic t_renew;
		@(posedge hclk);
		renewal_watch_mask <= 64'h8;
		block_written <= 64'h28;
		@(posedge hclk);
		block_written <= '0;
		@(negedge hclk);
		`CHK("flags", 64'h8, renewal_flags)
		`CHK("status", 1'b1, renewal_status)
		rdc(OFS_SYS, 16'h0800);
		bus(1'b1, OFS_TIM_B, 16'h0200);
		tick(7'h02);
		`CHK("flags", 64'h8, renewal_flags)
		tick(7'h04);
		rdc(OFS_PEND_A, 16'h0002);
		`CHK("flags", 64'h0, renewal_flags)
		`CHK("status", 1'b0, renewal_status)
		bus(1'b1, OFS_TIM_A, 16'h0906);
		@(posedge hclk);
		block_written <= 64'h8;
		@(posedge hclk);
		block_written <= '0;
		tick(7'h09);
		`CHK("flags", 64'h8, renewal_flags)
		bus(1'b1, OFS_EN_A, 16'h0000);
		tick(7'h02);
		`CHK("flags", 64'h8, renewal_flags)
		bus(1'b1, OFS_EN_B, 16'hFFFF);
		tick(7'h02);
		rdc(OFS_PEND_B, 16'h0002);
		`CHK("flags", 64'h0, renewal_flags)
		$display("test renewal done");
	endtask

	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_mail;
		t_retrig;
		t_same;
		t_member;
		t_alarm;
		t_renew;
		wrap_up;
	end
endmodule
